/* capture_pkg.sv */
// Purpose: Shared constants for the state and timing capture front end.
// Assumes: AHB-Lite word registers, 125 MHz hclk, four pods of sixteen channels.
// Notes: Byte offsets, field positions, reset values and cycle counts live here.
package capture_pkg;

  // Geometry of the pod and clock inputs.
  localparam int POD_COUNT = 4;
  localparam int POD_WIDTH = 16;
  localparam int CLK_COUNT = 4;
  localparam int QUAL_COUNT = 4;
  localparam int FULL_WIDTH = 68;
  localparam int HALF_WIDTH = 34;
  localparam int PAIR_WIDTH = 17;

  // Acquisition memory: 64 K words per channel, tags take the upper half.
  localparam int MEM_WORDS = 65536;
  localparam int MEM_AW = 16;
  localparam logic [16:0] FULL_LIMIT = 17'h1_0000;
  localparam logic [16:0] TAG_LIMIT = 17'h0_8000;
  localparam logic [15:0] TAG_BASE = 16'h8000;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POD_MODE = 8'h04;
  localparam logic [7:0] OFS_MASTER_ARR = 8'h08;
  localparam logic [7:0] OFS_SLAVE_ARR = 8'h0C;
  localparam logic [7:0] OFS_SAMPLE_DIV = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_WR_COUNT = 8'h18;
  localparam logic [7:0] OFS_MEM_INDEX = 8'h1C;
  localparam logic [7:0] OFS_MEM_DATA0 = 8'h20;
  localparam logic [7:0] OFS_MEM_DATA1 = 8'h24;
  localparam logic [7:0] OFS_MEM_DATA2 = 8'h28;
  localparam logic [7:0] OFS_LIVE = 8'h2C;

  // Control register fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_TIMING = 1;
  localparam int CTRL_HALF = 2;
  localparam int CTRL_TAG_EN = 3;
  localparam int CTRL_TAG_STATE = 4;
  localparam int CTRL_POD_SEL = 5;
  localparam int CTRL_BITS = 6;

  // Clocking arrangement fields.
  localparam int ARR_RISE = 0;
  localparam int ARR_FALL = 4;
  localparam int ARR_QEN = 8;
  localparam int ARR_QLVL = 12;
  localparam int ARR_QOR = 16;
  localparam int ARR_BITS = 18;

  // Pod clock arrangement codes.
  localparam logic [1:0] POD_OFF = 2'h0;
  localparam logic [1:0] POD_MASTER = 2'h1;
  localparam logic [1:0] POD_SLAVE = 2'h2;
  localparam logic [1:0] POD_DEMUX = 2'h3;

  // Reset values.
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] POD_MODE_RESET = 8'h55;
  localparam logic [17:0] ARR_RESET = 18'h0_0001;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // Timing capture intervals and the hclk rate.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int FULL_MIN_PS = 4000;
  localparam int HALF_MIN_PS = 2000;
  localparam int FULL_MIN_CYC = (FULL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HALF_MIN_CYC = (HALF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Acquisition sequencer states.
  typedef enum logic [2:0] {
    ACQ_IDLE = 3'b001,
    ACQ_RUN = 3'b010,
    ACQ_DONE = 3'b100
  } acq_state_t;

endpackage

/* state_capture_clocking.sv */
// Purpose: Clock qualification and acquisition memory writer for four logic analyzer pods.
// Assumes: Target clocks, qualifiers and data are asynchronous and sampled by hclk.
// Notes: Pulses narrower than one hclk period may be missed; sampling is at most one per cycle.
// What this block does
// [RULE1] State capture uses target clock matches; timing capture uses internal divider ticks.
// [RULE2] Master-assigned pods are written to memory on every master arrangement match.
// [RULE3] Slave pods are latched on slave match and stored at the next master match.
// [RULE4] Only the last slave capture before a master match is stored.
// [RULE5] Demux uses both arrangements on the even pod of a pair only.
// [RULE6] Demux slave match latches shared channels; master match stores both sets.
// [RULE7] Selected edges are ORed; each edge term is ANDed with its qualifiers.
// [RULE8] Qualifiers within a group combine by AND or OR as configured.
// [RULE9] Match is group one (clocks 1-2, qualifiers 1-2) OR group two (3-4, 3-4).
// [RULE10] Four clock inputs and four qualifier inputs build the arrangements.
// [RULE11] First two clocks belong to pod pair one, next two to pair two.
// [RULE12] Every clock line is also stored as an ordinary data channel; half-channel words keep only the selected pod's clock of each pair.
// [RULE13] Clock lines beyond the master clocks would serve only as data.
// [RULE14] Full-channel state stores both pods of each pair, 64 K deep.
// [RULE15] Full-channel state with tags splits memory evenly between data and tags.
// [RULE16] Half-channel state stores one chosen pod per pair, 128 K deep, no tags.
// [RULE17] Conventional timing stores one sample at every sampling interval.
// [RULE18] Full-channel timing samples all channels, never faster than 4 ns.
// [RULE19] Half-channel timing samples one pod per pair, never faster than 2 ns.
// [RULE20] Clock edges come from comparing synchronised clocks with their previous value.
`timescale 1ns/1ps
module state_capture_clocking (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Target system pins
  input wire logic [3:0] target_clk,
  input wire logic qualifier_one,
  input wire logic qualifier_two,
  input wire logic qualifier_three,
  input wire logic qualifier_four,
  input wire logic [63:0] pod_data,
  // Acquisition status
  output logic acq_busy,
  output logic acq_done
);

  // Evaluates one clocking arrangement against the present edges and qualifier levels.
  function automatic logic arr_match(input logic [17:0] arr, input logic [3:0] rise,
                                     input logic [3:0] fall, input logic [3:0] qual);
    logic [1:0] grp;
    logic edge_hit;
    logic qterm;
    logic [1:0] qen;
    logic [1:0] qok;
    grp = 2'b00;
    for (int g = 0; g < 2; g++) begin
      edge_hit = |((arr[capture_pkg::ARR_RISE + 2*g +: 2] & rise[2*g +: 2]) |
                   (arr[capture_pkg::ARR_FALL + 2*g +: 2] & fall[2*g +: 2])); // [RULE7]
      qen = arr[capture_pkg::ARR_QEN + 2*g +: 2];
      qok = ~(qual[2*g +: 2] ^ arr[capture_pkg::ARR_QLVL + 2*g +: 2]);
      if (arr[capture_pkg::ARR_QOR + g]) begin
        qterm = (qen == 2'b00) | (|(qen & qok)); // [RULE8]
      end else begin
        qterm = &(~qen | qok); // [RULE8]
      end
      grp[g] = edge_hit & qterm; // [RULE7]
    end
    return |grp; // [RULE9]
  endfunction

  // Input synchronisers: first stage feeds only the second.
  logic [3:0] clk_meta_r;
  logic [3:0] clk_sync_r;
  logic [3:0] clk_prev_r;
  logic [3:0] qual_meta_r;
  logic [3:0] qual_sync_r;
  logic [63:0] pod_meta_r;
  logic [63:0] pod_sync_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_meta_r <= 4'h0;
      clk_sync_r <= 4'h0;
      clk_prev_r <= 4'h0;
      qual_meta_r <= 4'h0;
      qual_sync_r <= 4'h0;
      pod_meta_r <= 64'h0000_0000_0000_0000;
      pod_sync_r <= 64'h0000_0000_0000_0000;
    end else begin
      clk_meta_r <= target_clk; // [RULE10]
      clk_sync_r <= clk_meta_r;
      clk_prev_r <= clk_sync_r; // [RULE20]
      qual_meta_r <= {qualifier_four, qualifier_three, qualifier_two, qualifier_one}; // [RULE10]
      qual_sync_r <= qual_meta_r;
      pod_meta_r <= pod_data;
      pod_sync_r <= pod_meta_r;
    end
  end

  // Registers written by software.
  logic [5:0] ctrl_r;
  logic [5:0] ctrl_nxt;
  logic [7:0] pod_mode_r;
  logic [7:0] pod_mode_nxt;
  logic [17:0] master_arr_r;
  logic [17:0] master_arr_nxt;
  logic [17:0] slave_arr_r;
  logic [17:0] slave_arr_nxt;
  logic [15:0] sample_div_r;
  logic [15:0] sample_div_nxt;
  logic [15:0] mem_index_r;
  logic [15:0] mem_index_nxt;
  logic start_nxt;
  logic stop_nxt;
  logic start_r;
  logic stop_r;

  // Bus slave state.
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic [31:0] hrdata_r;
  logic [67:0] mem_rd_r;

  // Acquisition state.
  capture_pkg::acq_state_t acq_r;
  capture_pkg::acq_state_t acq_nxt;
  logic [16:0] ptr_r;
  logic [16:0] ptr_nxt;
  logic half_phase_r;
  logic half_phase_nxt;
  logic [33:0] half_hold_r;
  logic [33:0] half_hold_nxt;
  logic [15:0] div_cnt_r;
  logic [15:0] div_cnt_nxt;
  logic [31:0] time_tag_r;
  logic [31:0] time_tag_nxt;
  logic [31:0] state_tag_r;
  logic [31:0] state_tag_nxt;
  logic [63:0] slave_lat_r;
  logic [63:0] slave_lat_nxt;

  // Memory write port.
  logic mem_we;
  logic tag_we;
  logic [15:0] mem_waddr;
  logic [67:0] mem_wdata;
  logic [67:0] acq_mem [0:capture_pkg::MEM_WORDS-1];

  // Clock edge detection and arrangement matching.
  logic [3:0] rise;
  logic [3:0] fall;
  logic master_hit;
  logic slave_hit;
  logic div_tick;
  logic store_evt;
  logic [67:0] full_word;
  logic [33:0] half_word;
  logic [16:0] limit;

  assign rise = clk_sync_r & ~clk_prev_r; // [RULE20]
  assign fall = ~clk_sync_r & clk_prev_r; // [RULE20]
  assign master_hit = arr_match(master_arr_r, rise, fall, qual_sync_r);
  assign slave_hit = arr_match(slave_arr_r, rise, fall, qual_sync_r);

  // Builds the stored word from live, slave and demux channel sets.
  always_comb begin
    full_word = 68'h0;
    full_word[67:64] = clk_sync_r; // [RULE12] [RULE13]
    if (ctrl_r[capture_pkg::CTRL_TIMING]) begin
      full_word[63:0] = pod_sync_r; // [RULE18]
    end else begin
      for (int p = 0; p < capture_pkg::POD_COUNT; p++) begin
        case (pod_mode_r[2*p +: 2])
          capture_pkg::POD_MASTER: full_word[16*p +: 16] = pod_sync_r[16*p +: 16]; // [RULE2]
          capture_pkg::POD_SLAVE: full_word[16*p +: 16] = slave_lat_r[16*p +: 16]; // [RULE3]
          default: begin
          end
        endcase
      end
      for (int pp = 0; pp < 2; pp++) begin
        if (pod_mode_r[4*pp +: 2] == capture_pkg::POD_DEMUX) begin
          full_word[32*pp +: 16] = pod_sync_r[32*pp +: 16]; // [RULE5]
          full_word[32*pp + 16 +: 16] = slave_lat_r[32*pp +: 16]; // [RULE6]
        end
      end
    end
  end

  // Half-channel sample: one selected pod and its pair's clock per pod pair.
  always_comb begin
    half_word = 34'h0;
    for (int pp = 0; pp < 2; pp++) begin
      if (ctrl_r[capture_pkg::CTRL_POD_SEL]) begin
        half_word[17*pp +: 17] = {full_word[64 + 2*pp + 1], full_word[32*pp + 16 +: 16]}; // [RULE11]
      end else begin
        half_word[17*pp +: 17] = {full_word[64 + 2*pp], full_word[32*pp +: 16]}; // [RULE11]
      end
    end
  end

  // Timing mode sampling divider: interval is sample_div + 1 hclk periods.
  always_comb begin
    div_tick = (div_cnt_r == 16'h0000);
    if (acq_r != capture_pkg::ACQ_RUN || div_tick) begin
      div_cnt_nxt = sample_div_r;
    end else begin
      div_cnt_nxt = div_cnt_r - 16'h0001;
    end
  end

  // One store per master match in state capture, one per tick in timing capture.
  assign store_evt = (acq_r == capture_pkg::ACQ_RUN) &&
                     (ctrl_r[capture_pkg::CTRL_TIMING] ? div_tick : master_hit); // [RULE1] [RULE17]

  // Tags are kept only in full-channel state capture and halve the data depth.
  logic tag_mode;
  assign tag_mode = ctrl_r[capture_pkg::CTRL_TAG_EN] && !ctrl_r[capture_pkg::CTRL_HALF] &&
                    !ctrl_r[capture_pkg::CTRL_TIMING]; // [RULE15] [RULE16]
  assign limit = tag_mode ? capture_pkg::TAG_LIMIT : capture_pkg::FULL_LIMIT; // [RULE14] [RULE15]

  // Acquisition sequencer, slave latch, packing and tag counters.
  always_comb begin
    acq_nxt = acq_r;
    ptr_nxt = ptr_r;
    half_phase_nxt = half_phase_r;
    half_hold_nxt = half_hold_r;
    slave_lat_nxt = slave_lat_r;
    time_tag_nxt = time_tag_r + 32'h0000_0001;
    state_tag_nxt = state_tag_r;
    mem_we = 1'b0;
    tag_we = 1'b0;
    mem_waddr = ptr_r[15:0];
    mem_wdata = full_word;
    if (slave_hit && !ctrl_r[capture_pkg::CTRL_TIMING]) begin
      slave_lat_nxt = pod_sync_r; // [RULE3] [RULE4] [RULE6]
    end
    if (master_hit && !ctrl_r[capture_pkg::CTRL_TIMING]) begin
      state_tag_nxt = state_tag_r + 32'h0000_0001;
    end
    case (acq_r)
      capture_pkg::ACQ_IDLE: begin
        if (start_r) begin
          acq_nxt = capture_pkg::ACQ_RUN;
          ptr_nxt = 17'h0_0000;
          half_phase_nxt = 1'b0;
          time_tag_nxt = 32'h0000_0000;
          state_tag_nxt = 32'h0000_0000;
        end
      end
      capture_pkg::ACQ_RUN: begin
        if (stop_r) begin
          acq_nxt = capture_pkg::ACQ_IDLE;
        end else if (store_evt) begin
          if (ctrl_r[capture_pkg::CTRL_HALF]) begin
            if (half_phase_r) begin
              mem_we = 1'b1;
              mem_wdata = {half_word, half_hold_r}; // [RULE16] [RULE19]
              ptr_nxt = ptr_r + 17'h0_0001;
            end else begin
              half_hold_nxt = half_word;
            end
            half_phase_nxt = !half_phase_r;
          end else begin
            mem_we = 1'b1; // [RULE2] [RULE14] [RULE17]
            tag_we = tag_mode; // [RULE15]
            ptr_nxt = ptr_r + 17'h0_0001;
          end
          if (ptr_nxt == limit) begin
            acq_nxt = capture_pkg::ACQ_DONE;
          end
        end
      end
      capture_pkg::ACQ_DONE: begin
        if (start_r) begin
          acq_nxt = capture_pkg::ACQ_RUN;
          ptr_nxt = 17'h0_0000;
          half_phase_nxt = 1'b0;
          time_tag_nxt = 32'h0000_0000;
          state_tag_nxt = 32'h0000_0000;
        end else if (stop_r) begin
          acq_nxt = capture_pkg::ACQ_IDLE;
        end
      end
      default: acq_nxt = capture_pkg::ACQ_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_r <= capture_pkg::ACQ_IDLE;
      ptr_r <= 17'h0_0000;
      half_phase_r <= 1'b0;
      half_hold_r <= 34'h0;
      div_cnt_r <= capture_pkg::DIV_RESET;
      time_tag_r <= 32'h0000_0000;
      state_tag_r <= 32'h0000_0000;
      slave_lat_r <= 64'h0000_0000_0000_0000;
      acq_busy <= 1'b0;
      acq_done <= 1'b0;
    end else begin
      acq_r <= acq_nxt;
      ptr_r <= ptr_nxt;
      half_phase_r <= half_phase_nxt;
      half_hold_r <= half_hold_nxt;
      div_cnt_r <= div_cnt_nxt;
      time_tag_r <= time_tag_nxt;
      state_tag_r <= state_tag_nxt;
      slave_lat_r <= slave_lat_nxt;
      acq_busy <= (acq_nxt == capture_pkg::ACQ_RUN);
      acq_done <= (acq_nxt == capture_pkg::ACQ_DONE);
    end
  end

  // Acquisition memory. Tags share the array so one depth setting serves both uses.
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      acq_mem[mem_waddr] <= mem_wdata;
    end
    if (tag_we) begin
      acq_mem[mem_waddr | capture_pkg::TAG_BASE] <= {36'h0,
        ctrl_r[capture_pkg::CTRL_TAG_STATE] ? state_tag_r : time_tag_r}; // [RULE15]
    end
    mem_rd_r <= acq_mem[mem_index_r];
  end

  // Bus slave: zero wait states, read data registered at the address phase edge.
  logic addr_ok;
  logic [7:0] rd_ofs;
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_ofs = haddr[7:0];

  always_comb begin
    wr_pend_nxt = addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
    wr_addr_nxt = haddr[7:0];
    hrdata_nxt = hrdata_r;
    if (addr_ok && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000) begin
        case (rd_ofs)
          capture_pkg::OFS_CTRL: hrdata_nxt = {26'h0, ctrl_r};
          capture_pkg::OFS_POD_MODE: hrdata_nxt = {24'h0, pod_mode_r};
          capture_pkg::OFS_MASTER_ARR: hrdata_nxt = {14'h0, master_arr_r};
          capture_pkg::OFS_SLAVE_ARR: hrdata_nxt = {14'h0, slave_arr_r};
          capture_pkg::OFS_SAMPLE_DIV: hrdata_nxt = {16'h0, sample_div_r};
          capture_pkg::OFS_STATUS: hrdata_nxt = {29'h0, acq_r};
          capture_pkg::OFS_WR_COUNT: hrdata_nxt = {14'h0, ptr_r, half_phase_r};
          capture_pkg::OFS_MEM_INDEX: hrdata_nxt = {16'h0, mem_index_r};
          capture_pkg::OFS_MEM_DATA0: hrdata_nxt = mem_rd_r[31:0];
          capture_pkg::OFS_MEM_DATA1: hrdata_nxt = mem_rd_r[63:32];
          capture_pkg::OFS_MEM_DATA2: hrdata_nxt = {28'h0, mem_rd_r[67:64]};
          capture_pkg::OFS_LIVE: hrdata_nxt = {24'h0, qual_sync_r, clk_sync_r};
          default: hrdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes land in the data phase with hwdata.
  always_comb begin
    ctrl_nxt = ctrl_r;
    pod_mode_nxt = pod_mode_r;
    master_arr_nxt = master_arr_r;
    slave_arr_nxt = slave_arr_r;
    sample_div_nxt = sample_div_r;
    mem_index_nxt = mem_index_r;
    start_nxt = 1'b0;
    stop_nxt = 1'b0;
    if (wr_pend_r) begin
      case (wr_addr_r)
        capture_pkg::OFS_CTRL: begin
          ctrl_nxt = hwdata[5:0];
          start_nxt = hwdata[capture_pkg::CTRL_RUN];
          stop_nxt = !hwdata[capture_pkg::CTRL_RUN];
        end
        capture_pkg::OFS_POD_MODE: pod_mode_nxt = hwdata[7:0];
        capture_pkg::OFS_MASTER_ARR: master_arr_nxt = hwdata[17:0];
        capture_pkg::OFS_SLAVE_ARR: slave_arr_nxt = hwdata[17:0];
        capture_pkg::OFS_SAMPLE_DIV: sample_div_nxt = hwdata[15:0];
        capture_pkg::OFS_MEM_INDEX: mem_index_nxt = hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= capture_pkg::CTRL_RESET;
      pod_mode_r <= capture_pkg::POD_MODE_RESET;
      master_arr_r <= capture_pkg::ARR_RESET;
      slave_arr_r <= capture_pkg::ARR_RESET;
      sample_div_r <= capture_pkg::DIV_RESET;
      mem_index_r <= 16'h0000;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      pod_mode_r <= pod_mode_nxt;
      master_arr_r <= master_arr_nxt;
      slave_arr_r <= slave_arr_nxt;
      sample_div_r <= sample_div_nxt;
      mem_index_r <= mem_index_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;

endmodule

/* state_capture_asserts.sv */
// Purpose: Port-level checks on the capture front end.
// Assumes: One hclk domain with an active-low asynchronous reset.
// Notes: Memory contents are judged by the bench, not here.
`timescale 1ns/1ps
module state_capture_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Status
  input wire logic acq_busy,
  input wire logic acq_done
);
  logic wr_r;
  logic wr_nxt;
  logic [3:0] gap_r;
  logic [3:0] gap_nxt;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Control writes pass a short pipeline, so holds are judged once it drained.
  always_comb begin
    wr_nxt = hsel && hready && htrans[1] && hwrite;
    gap_nxt = wr_r ? 4'h0 : ((gap_r == 4'hF) ? gap_r : gap_r + 4'h1);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      gap_r <= 4'hF;
    end else begin
      wr_r <= wr_nxt;
      gap_r <= gap_nxt;
    end
  end
  AST_READY: assert property (hreadyout)
    else $error("Wait state inserted.");
  AST_OKAY: assert property (!hresp)
    else $error("Error response given.");
  AST_HOLD: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("Read data changed without a read.");
  AST_EXCL: assert property (!(acq_busy && acq_done))
    else $error("Busy and done together.");
  AST_DONE_SRC: assert property ($rose(acq_done) |-> $past(acq_busy))
    else $error("Done without an acquisition.");
  AST_START: assert property ($rose(acq_busy) |-> gap_r <= 4'h4)
    else $error("Acquisition started without a control write.");
  AST_BUSY_HOLD: assert property (acq_busy && gap_r > 4'h3 |=> acq_busy || acq_done)
    else $error("Acquisition stopped by itself.");
  AST_DONE_HOLD: assert property (acq_done && gap_r > 4'h3 |=> acq_done)
    else $error("Done dropped without a control write.");
endmodule
bind state_capture_clocking state_capture_asserts state_capture_asserts_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .acq_busy(acq_busy), .acq_done(acq_done));

/* target_model.sv */
// Purpose: System under test that makes clock edges, qualifier levels and data.
// Assumes: Link clock period of 80 ns, clocks stand low between frames.
// Notes: Data is inverted after its hold time so stale values never look valid.
`timescale 1ns/1ps
module target_model (
  // Target pins
  output logic [3:0] target_clk,
  output logic qualifier_one,
  output logic qualifier_two,
  output logic qualifier_three,
  output logic qualifier_four,
  output logic [63:0] pod_data
);
  initial begin
    target_clk = 4'h0;
    {qualifier_four, qualifier_three, qualifier_two, qualifier_one} = 4'h0;
    pod_data = 64'h0000_0000_0000_0000;
  end
  // One frame: data and qualifiers, then one full clock pulse on line c.
  // The 2 ns lead keeps every pin change away from a rising hclk edge, so no sample races it.
  task automatic ev(input int c, input logic [63:0] d, input logic [3:0] q);
    #2 pod_data = d;
    {qualifier_four, qualifier_three, qualifier_two, qualifier_one} = q;
    #40 target_clk[c] = 1'b1;
    #40 target_clk[c] = 1'b0;
    #40 pod_data = ~d;
  endtask
endmodule

/* test_state_capture_clocking.sv */
// Purpose: Self-checking bench for the capture front end.
// Assumes: Zero wait state bus and a 125 MHz hclk.
// Notes: Full memory is filled only in timing mode, one sample per cycle.
`timescale 1ns/1ps
module test_state_capture_clocking;
  localparam logic [63:0] D1 = 64'hA1B2_C3D4_E5F6_0718;
  localparam logic [63:0] D2 = 64'h1357_9BDF_2468_ACE0;
  localparam logic [63:0] D3 = 64'h0F1E_2D3C_4B5A_6978;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready, hreadyout, hresp, acq_busy, acq_done;
  logic [31:0] hrdata;
  logic [3:0] target_clk;
  logic q1, q2, q3, q4;
  logic [63:0] pod_data;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  state_capture_clocking state_capture_clocking_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .target_clk(target_clk), .qualifier_one(q1), .qualifier_two(q2),
    .qualifier_three(q3), .qualifier_four(q4), .pod_data(pod_data),
    .acq_busy(acq_busy), .acq_done(acq_done));
  target_model target_model_inst (.target_clk(target_clk), .qualifier_one(q1),
    .qualifier_two(q2), .qualifier_three(q3), .qualifier_four(q4), .pod_data(pod_data));
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(hrdata, e);
  endtask
  // The array read lags the index by one cycle.
  task mr(input logic [31:0] i, input logic [31:0] e0, input logic [31:0] e1);
    wr(capture_pkg::OFS_MEM_INDEX, i);
    repeat (2) @(posedge hclk);
    rd(capture_pkg::OFS_MEM_DATA0, e0);
    rd(capture_pkg::OFS_MEM_DATA1, e1);
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(capture_pkg::OFS_CTRL, 32'h0000_0000);
    rd(capture_pkg::OFS_POD_MODE, 32'h0000_0055);
    rd(capture_pkg::OFS_MASTER_ARR, 32'h0000_0001);
    rd(capture_pkg::OFS_SLAVE_ARR, 32'h0000_0001);
    rd(capture_pkg::OFS_STATUS, 32'h0000_0001);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    $display("test reset done");
    wr(capture_pkg::OFS_POD_MODE, 32'h0000_0059);
    wr(capture_pkg::OFS_SLAVE_ARR, 32'h0000_0002);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0001);
    target_model_inst.ev(1, D1, 4'h0);
    target_model_inst.ev(1, D2, 4'h0);
    target_model_inst.ev(0, D3, 4'h0);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0000);
    mr(32'h0000_0000, {D2[31:16], D3[15:0]}, D3[63:32]);
    $display("test slave done");
    wr(capture_pkg::OFS_POD_MODE, 32'h0000_0055);
    wr(capture_pkg::OFS_MASTER_ARR, 32'h0000_1105);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0001);
    target_model_inst.ev(0, D1, 4'h0);
    target_model_inst.ev(2, D2, 4'h0);
    target_model_inst.ev(0, D3, 4'h1);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0000);
    mr(32'h0000_0000, D2[31:0], D2[63:32]);
    mr(32'h0000_0001, D3[31:0], D3[63:32]);
    $display("test qualifier done");
    wr(capture_pkg::OFS_MASTER_ARR, 32'h0000_0001);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0005);
    target_model_inst.ev(0, D1, 4'h0);
    target_model_inst.ev(0, D2, 4'h0);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0000);
    mr(32'h0000_0000, {D1[46:32], 1'b1, D1[15:0]},
      {D2[44:32], 1'b1, D2[15:0], 1'b0, D1[47]});
    $display("test half done");
    wr(capture_pkg::OFS_POD_MODE, 32'h0000_0053);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0019);
    target_model_inst.ev(1, D1, 4'h0);
    target_model_inst.ev(0, D2, 4'h0);
    target_model_inst.ev(0, D3, 4'h0);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0000);
    mr(32'h0000_0000, {D1[15:0], D2[15:0]}, D2[63:32]);
    rd(capture_pkg::OFS_MEM_DATA2, 32'h0000_0001);
    mr(32'h0000_8001, 32'h0000_0001, 32'h0000_0000);
    $display("test demux done");
    wr(capture_pkg::OFS_SAMPLE_DIV, 32'h0000_0000);
    wr(capture_pkg::OFS_CTRL, 32'h0000_0003);
    while (acq_done !== 1'b1) @(posedge hclk);
    rd(capture_pkg::OFS_STATUS, 32'h0000_0004);
    mr(32'h0000_0064, ~D3[31:0], ~D3[63:32]);
    $display("test timing done");
    end_sim;
  end
endmodule
